/* bench/charge_state_led_alert_logic_tb.sv */
// Purpose: Self-checking bench for the charge, LED and alert logic.
// Assumes: Millisecond tick shortened to four cycles.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ps
module charge_state_led_alert_logic_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] got;
    logic [15:0] meas = 16'h0000;
    logic tick = 1'b0;
    logic [6:0] pct = 7'h00;
    logic [15:0] ext = 16'h0000;
    logic relax = 1'b0;
    logic ocv = 1'b0;
    logic [15:0] chain;
    logic [3:0] leds;
    logic alert_n;
    logic ts_oe;
    logic btn = 1'b0;
    int on_cnt;
    logic [15:0] mask;
    int mismatches = 0;
    int n_compared = 0;
    int lit;
    int cases[5] = '{0, 25, 26, 67, 100};
    // Free-running core clock.
    always #25 clk = ~clk;
    charge_led_alert #(.P_MS_CYCLES(4)) dut (
        .i_core_clk(clk), .i_resetn(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_temperature(meas),
        .i_avg_current(meas), .i_voltage(meas), .i_charge_percent(pct),
        .i_window_charge(meas), .i_taper_tick(tick), .i_remaining_capacity(meas),
        .i_capacity_update(tick), .i_charge_allow_set(tick), .i_relax_enter(relax),
        .i_ocv_sample(ocv), .i_ext_flags(ext), .i_ts_measure(tick),
        .i_display_button_input(btn), .o_led1_or_shift_clock_pin(leds[0]),
        .o_led2_or_shift_data_pin(leds[1]), .o_led3_pin(leds[2]),
        .o_led4_pin(leds[3]), .o_alert_pin1_n(alert_n), .o_alert_pin12_n(),
        .o_alert_pin13_n(), .o_thermistor_sense_out(), .o_thermistor_sense_oe(ts_oe));
    // Cycles lit per one-second blink period with four-cycle milliseconds.
    function automatic logic [15:0] blink_cycles(input logic [6:0] p);
        blink_cycles = 16'(((p > 7'd90) ? 90 : int'(p)) * 40);
    endfunction
    shift_chain_model chain_model (
        .i_shift_clock(leds[0]), .i_shift_data(leds[1]), .o_parallel(chain));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial begin
        #(40000 * 50);
        mismatches++;
        close_out();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h1e8ac025));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rreg(4'h0);
        chk("led cfg", got, 16'h0000);
        rreg(4'h1);
        chk("alert mask", got, 16'h0000);
        chk("idle alert", {15'h0, alert_n}, 16'h0001);
        pct <= 7'($urandom_range(100, 1));
        wreg(4'h0, 16'h007B);
        repeat (60) @(posedge clk);
        lit = (int'(pct) * 8 + 99) / 100;
        chk("chain", {8'h00, chain[7:0]}, 16'((1 << lit) - 1));
        for (int i = 0; i < 6; i++) begin
            pct <= 7'((i < 5) ? cases[i] : $urandom_range(100, 0));
            wreg(4'h0, 16'h000A);
            repeat (10) @(posedge clk);
            lit = (int'(pct) + 24) / 25;
            chk("leds", {12'h000, leds}, 16'((1 << lit) - 1));
            chk("ts oe", {15'h0, ts_oe}, 16'h0000);
        end
        wreg(4'h0, 16'h0000);
        repeat (8) begin
            mask = 16'($urandom) & charge_led_pkg::EXT_FLAG_MASK;
            ext <= 16'($urandom);
            wreg(4'h1, mask);
            repeat (3) @(posedge clk);
            chk("alert", {15'h0, alert_n}, {15'h0, ~|(ext & mask)});
        end
        ocv <= 1'b1;
        @(posedge clk);
        ocv <= 1'b0;
        rreg(4'hD);
        chk("ocv set", {15'h0, got[7]}, 16'h0001);
        relax <= 1'b1;
        @(posedge clk);
        relax <= 1'b0;
        rreg(4'hD);
        chk("ocv clear", {15'h0, got[7]}, 16'h0000);
        meas <= 16'($urandom);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        rreg(4'hE);
        chk("rem cap", got, (meas > 16'h7FFF) ? 16'h7FFF : meas);
        // Single LED: hold the button one second, then count lit cycles over one period.
        btn <= 1'b1;
        pct <= 7'($urandom_range(100, 0));
        wreg(4'hB, 16'h0003);
        wreg(4'h0, 16'h0001);
        repeat (4100) @(posedge clk);
        on_cnt = 0;
        repeat (4000) begin
            @(posedge clk);
            on_cnt += int'(leds[0]);
        end
        chk("blink on", 16'(on_cnt), blink_cycles(pct));
        btn <= 1'b0;
        close_out();
    end
endmodule

/* bench/shift_chain_model.sv */
// Purpose: Two cascaded serial-in shift registers on the LED link.
// Assumes: Data is taken on the rising shift clock.
// Notes: The newest bit lands at position 0.
`timescale 1ns/1ps
module shift_chain_model (
    // Link pins.
    input wire logic i_shift_clock,
    input wire logic i_shift_data,
    // Parallel outputs.
    output logic [15:0] o_parallel
);
    // Register contents start cleared so a missing frame shows up.
    logic [15:0] chain_q = 16'h0000;
    // Each rising clock shifts one data bit in.
    always @(posedge i_shift_clock) begin
        chain_q <= {chain_q[14:0], i_shift_data};
    end
    assign o_parallel = chain_q;
endmodule

/* rtl/charge_led_alert.sv */
// Purpose: Over-temperature, termination, full-charge flags, LED display and alert.
// Assumes: Measurement strobes are one-cycle pulses synchronous to i_core_clk.
// Notes: Register reads return data in the cycle after the read strobe only.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module charge_led_alert #(
    parameter int P_MS_CYCLES = charge_led_pkg::MS_CYCLES
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Measurements.
    input wire logic signed [15:0] i_temperature,
    input wire logic signed [15:0] i_avg_current,
    input wire logic [15:0] i_voltage,
    input wire logic [6:0] i_charge_percent,
    input wire logic [15:0] i_window_charge,
    input wire logic i_taper_tick,
    input wire logic [15:0] i_remaining_capacity,
    input wire logic i_capacity_update,
    input wire logic i_charge_allow_set,
    input wire logic i_relax_enter,
    input wire logic i_ocv_sample,
    input wire logic [15:0] i_ext_flags,
    input wire logic i_ts_measure,
    input wire logic i_display_button_input,
    // LED and alert pins.
    output logic o_led1_or_shift_clock_pin,
    output logic o_led2_or_shift_data_pin,
    output logic o_led3_pin,
    output logic o_led4_pin,
    output logic o_alert_pin1_n,
    output logic o_alert_pin12_n,
    output logic o_alert_pin13_n,
    output logic o_thermistor_sense_out,
    output logic o_thermistor_sense_oe
);
    typedef struct packed {
        logic [7:0] led_cfg;
        logic [15:0] mask;
        logic [7:0] pack;
        logic [7:0] ot_qual;
        logic signed [15:0] ot_thr;
        logic signed [15:0] ot_rec;
        logic signed [15:0] dsg_thr;
        logic signed [15:0] taper_i;
        logic [15:0] chg_v;
        logic [15:0] taper_v;
        logic [7:0] full_charge_set_percent;
        logic [7:0] hold;
        logic [4:0] test;
        logic [15:0] fcc;
        logic [15:0] rc;
        logic discharge_overtemp_flag;
        logic fc;
        logic chg;
        logic ocv;
        logic [7:0] ot_cnt;
        logic [1:0] taper_cnt;
        logic [14:0] ms_cnt;
        logic [9:0] blink_ms;
        logic [10:0] btn_ms;
        logic disp_on;
        logic [7:0] hold_cnt;
        logic sh_req;
        charge_led_pkg::sh_state_t sh;
        logic [4:0] sh_bits;
        logic [4:0] last_lit;
        logic led1;
        logic led2;
        logic led3;
        logic led4;
        logic alert1_n;
        logic alert12_n;
        logic alert13_n;
        logic ts_out;
        logic ts_oe;
        logic [15:0] rdata;
    } st_t;

    st_t s;
    st_t next_s;
    logic ms_tick;
    logic sec_tick;
    logic hot_dsg;
    logic taper_ok;
    logic term;
    logic hold_done;
    logic refresh;
    logic btn_fire;
    logic tst;
    logic ext;
    logic alert;
    logic [15:0] flags;
    logic [4:0] ext_n;
    logic [4:0] lit4;
    logic [4:0] shown_x;
    logic [9:0] on_ms;
    logic [6:0] pct_cap;
    charge_led_pkg::disp_mode_t mode;

    // Number of LEDs lit out of n, rounding a partial share up.
    function automatic logic [4:0] lit_count(input logic [6:0] pct, input logic [4:0] n);
        logic [11:0] prod;
        prod = 12'(pct) * 12'(n) + 12'(charge_led_pkg::PCT_FULL) - 12'h001;
        lit_count = 5'(prod / 12'(charge_led_pkg::PCT_FULL));
    endfunction

    // Next-state computation for every register of the block.
    always_comb begin
        next_s = s;
        ms_tick = s.ms_cnt == 15'(P_MS_CYCLES - 1);
        sec_tick = ms_tick && s.blink_ms == charge_led_pkg::SEC_LAST_MS;
        next_s.ms_cnt = ms_tick ? '0 : s.ms_cnt + 15'h0001;
        if (ms_tick) begin
            next_s.blink_ms = sec_tick ? '0 : s.blink_ms + 10'h001;
        end
        flags = i_ext_flags & charge_led_pkg::EXT_FLAG_MASK;
        flags[charge_led_pkg::FLG_OTD] = s.discharge_overtemp_flag;
        flags[charge_led_pkg::FLG_FC] = s.fc;
        flags[charge_led_pkg::FLG_CHG] = s.chg;
        flags[charge_led_pkg::FLG_OCV] = s.ocv;

        // Register writes.
        if (i_wr) begin
            case (i_addr)
                charge_led_pkg::A_LED_CFG: next_s.led_cfg = i_wdata[7:0];
                charge_led_pkg::A_ALERT_MASK: next_s.mask = i_wdata;
                charge_led_pkg::A_PACK_CFG: next_s.pack = i_wdata[7:0];
                charge_led_pkg::A_OT_QUAL: next_s.ot_qual = i_wdata[7:0];
                charge_led_pkg::A_OT_THR: next_s.ot_thr = i_wdata;
                charge_led_pkg::A_OT_REC: next_s.ot_rec = i_wdata;
                charge_led_pkg::A_DSG_THR: next_s.dsg_thr = i_wdata;
                charge_led_pkg::A_TAPER_I: next_s.taper_i = i_wdata;
                charge_led_pkg::A_CHG_V: next_s.chg_v = i_wdata;
                charge_led_pkg::A_TAPER_V: next_s.taper_v = i_wdata;
                charge_led_pkg::A_FULL_CHARGE_SET_PERCENT: next_s.full_charge_set_percent = i_wdata[7:0];
                charge_led_pkg::A_HOLD: next_s.hold = i_wdata[7:0];
                charge_led_pkg::A_LED_TEST: next_s.test = i_wdata[4:0];
                charge_led_pkg::A_FULL_CAP: next_s.fcc = i_wdata;
                default: ;
            endcase
        end

        // Register reads; data stand only in the cycle after the strobe.
        next_s.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                charge_led_pkg::A_LED_CFG: next_s.rdata = {8'h00, s.led_cfg};
                charge_led_pkg::A_ALERT_MASK: next_s.rdata = s.mask;
                charge_led_pkg::A_PACK_CFG: next_s.rdata = {8'h00, s.pack};
                charge_led_pkg::A_OT_QUAL: next_s.rdata = {8'h00, s.ot_qual};
                charge_led_pkg::A_OT_THR: next_s.rdata = s.ot_thr;
                charge_led_pkg::A_OT_REC: next_s.rdata = s.ot_rec;
                charge_led_pkg::A_DSG_THR: next_s.rdata = s.dsg_thr;
                charge_led_pkg::A_TAPER_I: next_s.rdata = s.taper_i;
                charge_led_pkg::A_CHG_V: next_s.rdata = s.chg_v;
                charge_led_pkg::A_TAPER_V: next_s.rdata = s.taper_v;
                charge_led_pkg::A_FULL_CHARGE_SET_PERCENT: next_s.rdata = {8'h00, s.full_charge_set_percent};
                charge_led_pkg::A_HOLD: next_s.rdata = {8'h00, s.hold};
                charge_led_pkg::A_LED_TEST: next_s.rdata = {11'h000, s.test};
                charge_led_pkg::A_FLAGS: next_s.rdata = flags;
                charge_led_pkg::A_REM_CAP: next_s.rdata = (s.rc > charge_led_pkg::REPORT_MAX) ?
                    charge_led_pkg::REPORT_MAX : s.rc;
                charge_led_pkg::A_FULL_CAP: next_s.rdata = s.fcc;
                default: next_s.rdata = '0;
            endcase
        end

        // Discharge over-temperature qualification, recovery and disable.
        hot_dsg = i_temperature >= s.ot_thr && i_avg_current <= -s.dsg_thr;
        if (s.ot_qual == 8'h00) begin
            next_s.discharge_overtemp_flag = 1'b0;
            next_s.ot_cnt = '0;
        end else begin
            if (sec_tick) begin
                next_s.ot_cnt = !hot_dsg ? '0 : (&s.ot_cnt ? s.ot_cnt : s.ot_cnt + 8'h01);
            end
            if (i_temperature <= s.ot_rec) begin
                next_s.discharge_overtemp_flag = 1'b0;
            end
            if (sec_tick && hot_dsg && ({1'b0, s.ot_cnt} + 9'h001 >= {1'b0, s.ot_qual})) begin
                next_s.discharge_overtemp_flag = 1'b1;
            end
        end

        // Charge termination over two consecutive taper windows.
        taper_ok = i_avg_current < s.taper_i && i_window_charge > charge_led_pkg::TAPER_DELTA_MIN
            && {1'b0, i_voltage} > {1'b0, s.chg_v} - {1'b0, s.taper_v};
        term = 1'b0;
        if (i_taper_tick) begin
            if (!taper_ok) begin
                next_s.taper_cnt = '0;
            end else if (s.taper_cnt == charge_led_pkg::TAPER_LAST_WIN) begin
                term = 1'b1;
                next_s.taper_cnt = '0;
            end else begin
                next_s.taper_cnt = s.taper_cnt + 2'h1;
            end
        end
        if (term) begin
            next_s.chg = 1'b0;
        end
        if (i_charge_allow_set) begin
            next_s.chg = 1'b1;
        end
        if (i_capacity_update) begin
            next_s.rc = i_remaining_capacity;
        end
        if (term && s.pack[charge_led_pkg::PACK_REMAINING_EQUALS_FULL_ENABLE_BIT]) begin
            next_s.rc = s.fcc;
        end
        if (s.full_charge_set_percent == charge_led_pkg::FULL_CHARGE_SET_PERCENT_DISABLED) begin
            if (i_charge_allow_set) begin
                next_s.fc = 1'b0;
            end
            if (term) begin
                next_s.fc = 1'b1;
            end
        end else begin
            next_s.fc = {1'b0, i_charge_percent} > s.full_charge_set_percent;
        end
        if (i_relax_enter) begin
            next_s.ocv = 1'b0;
        end
        if (i_ocv_sample) begin
            next_s.ocv = 1'b1;
        end

        // Display on-time, refresh and button qualification.
        mode = charge_led_pkg::disp_mode_t'(s.led_cfg[2:0]);
        ext = mode == charge_led_pkg::MODE_EXT_TWO || mode == charge_led_pkg::MODE_EXT_ONE;
        ext_n = {1'b0, s.led_cfg[7:charge_led_pkg::LED_CNT_LSB]} + 5'h01;
        tst = s.test[charge_led_pkg::TEST_EN_BIT];
        if (!i_display_button_input) begin
            next_s.btn_ms = '0;
        end else if (ms_tick && s.btn_ms != charge_led_pkg::BTN_HOLD_MS) begin
            next_s.btn_ms = s.btn_ms + 11'h001;
        end
        btn_fire = ms_tick && s.btn_ms == charge_led_pkg::BTN_HOLD_MS - 11'h001;
        hold_done = sec_tick && ({1'b0, s.hold_cnt} + 9'h001 >= {1'b0, s.hold});
        refresh = 1'b0;
        if (sec_tick) begin
            next_s.hold_cnt = hold_done ? '0 : s.hold_cnt + 8'h01;
        end
        if (mode == charge_led_pkg::MODE_NONE) begin
            next_s.disp_on = 1'b0;
        end else if (s.led_cfg[charge_led_pkg::LED_ON_BIT] && mode != charge_led_pkg::MODE_SINGLE) begin
            next_s.disp_on = 1'b1;
            refresh = hold_done;
        end else if (btn_fire) begin
            next_s.disp_on = 1'b1;
            next_s.hold_cnt = '0;
        end else if (hold_done) begin
            next_s.disp_on = 1'b0;
        end

        // Serial shift-out to external registers, one settle and one clock cycle per bit.
        lit4 = lit_count(i_charge_percent, 5'h04);
        shown_x = tst ? (s.test[0] ? ext_n : 5'h00)
            : (s.disp_on ? lit_count(i_charge_percent, ext_n) : 5'h00);
        if (refresh) begin
            next_s.sh_req = 1'b1;
        end
        case (s.sh)
            charge_led_pkg::SH_IDLE: begin
                if (ext && (shown_x != s.last_lit || s.sh_req)) begin
                    next_s.sh = charge_led_pkg::SH_DATA;
                    next_s.sh_bits = ext_n - 5'h01;
                    next_s.last_lit = shown_x;
                    next_s.sh_req = 1'b0;
                end
            end
            charge_led_pkg::SH_DATA: next_s.sh = charge_led_pkg::SH_CLK;
            charge_led_pkg::SH_CLK: begin
                if (s.sh_bits == 5'h00) begin
                    next_s.sh = charge_led_pkg::SH_IDLE;
                end else begin
                    next_s.sh_bits = s.sh_bits - 5'h01;
                    next_s.sh = charge_led_pkg::SH_DATA;
                end
            end
            default: next_s.sh = charge_led_pkg::SH_IDLE;
        endcase

        // LED pin drive per mode.
        pct_cap = (i_charge_percent > charge_led_pkg::BLINK_CAP_PCT) ?
            charge_led_pkg::BLINK_CAP_PCT : i_charge_percent;
        on_ms = 10'(pct_cap) * charge_led_pkg::MS_PER_PCT;
        next_s.led1 = 1'b0;
        next_s.led2 = 1'b0;
        next_s.led3 = 1'b0;
        next_s.led4 = 1'b0;
        case (mode)
            charge_led_pkg::MODE_SINGLE: begin
                next_s.led1 = tst ? s.test[0] : (s.disp_on && s.blink_ms < on_ms);
            end
            charge_led_pkg::MODE_FOUR: begin
                next_s.led1 = tst ? s.test[0] : (s.disp_on && lit4 > 5'h00);
                next_s.led2 = tst ? s.test[1] : (s.disp_on && lit4 > 5'h01);
                next_s.led3 = tst ? s.test[2] : (s.disp_on && lit4 > 5'h02);
                next_s.led4 = tst ? s.test[3] : (s.disp_on && lit4 > 5'h03);
            end
            charge_led_pkg::MODE_EXT_TWO, charge_led_pkg::MODE_EXT_ONE: begin
                next_s.led1 = next_s.sh == charge_led_pkg::SH_CLK;
                next_s.led2 = next_s.sh != charge_led_pkg::SH_IDLE
                    && next_s.sh_bits < next_s.last_lit;
            end
            default: ;
        endcase

        // Alert on the pin that the mode selects.
        alert = |(flags & s.mask);
        next_s.alert1_n = !(alert && (mode == charge_led_pkg::MODE_NONE
            || mode == charge_led_pkg::MODE_SINGLE));
        next_s.alert12_n = !(alert && mode == charge_led_pkg::MODE_EXT_TWO);
        next_s.alert13_n = !(alert && mode == charge_led_pkg::MODE_EXT_ONE);
        next_s.ts_out = 1'b0;
        next_s.ts_oe = alert && mode == charge_led_pkg::MODE_FOUR && !i_ts_measure;
    end

    // State register.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s <= '0;
            s.led_cfg <= charge_led_pkg::LED_CFG_RST;
            s.mask <= charge_led_pkg::ALERT_MASK_RST;
            s.pack <= charge_led_pkg::PACK_CFG_RST;
            s.full_charge_set_percent <= charge_led_pkg::FULL_CHARGE_SET_PERCENT_DISABLED;
            s.sh <= charge_led_pkg::SH_IDLE;
            s.alert1_n <= 1'b1;
            s.alert12_n <= 1'b1;
            s.alert13_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign o_rdata = s.rdata;
    assign o_led1_or_shift_clock_pin = s.led1;
    assign o_led2_or_shift_data_pin = s.led2;
    assign o_led3_pin = s.led3;
    assign o_led4_pin = s.led4;
    assign o_alert_pin1_n = s.alert1_n;
    assign o_alert_pin12_n = s.alert12_n;
    assign o_alert_pin13_n = s.alert13_n;
    assign o_thermistor_sense_out = s.ts_out;
    assign o_thermistor_sense_oe = s.ts_oe;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence sh_start_s;
        s.sh == charge_led_pkg::SH_IDLE ##1 s.sh == charge_led_pkg::SH_DATA;
    endsequence
    sequence sh_pulse_s;
        o_led1_or_shift_clock_pin ##1 !o_led1_or_shift_clock_pin;
    endsequence
    otd_disable_a: assert property (s.ot_qual == 8'h00 |=> !s.discharge_overtemp_flag)
        else $error("discharge overtemp flag set while disabled");
    otd_recover_a: assert property (s.ot_qual != 8'h00 && i_temperature <= s.ot_rec && !sec_tick
        |=> !s.discharge_overtemp_flag)
        else $error("discharge overtemp flag not cleared on recovery");
    rc_load_a: assert property (term && s.pack[charge_led_pkg::PACK_REMAINING_EQUALS_FULL_ENABLE_BIT]
        |=> s.rc == $past(s.fcc))
        else $error("remaining capacity not loaded on termination");
    fc_term_a: assert property (term && s.full_charge_set_percent == charge_led_pkg::FULL_CHARGE_SET_PERCENT_DISABLED
        |=> s.fc)
        else $error("full charge flag not set on termination");
    ocv_set_a: assert property (i_ocv_sample |=> s.ocv)
        else $error("open circuit flag not set");
    alert_pin_a: assert property (mode == charge_led_pkg::MODE_NONE && |(flags & s.mask)
        |=> !o_alert_pin1_n)
        else $error("alert not asserted for enabled flag");
    ts_drive_a: assert property (o_thermistor_sense_oe
        |-> $past(mode) == charge_led_pkg::MODE_FOUR && !$past(i_ts_measure))
        else $error("thermistor pin driven outside mode two or during measurement");
    shift_bit_a: assert property (sh_start_s |-> !o_led1_or_shift_clock_pin ##1 sh_pulse_s)
        else $error("shift clock did not follow settled data");
    shift_data_a: assert property ($rose(o_led1_or_shift_clock_pin)
        |-> $stable(o_led2_or_shift_data_pin))
        else $error("shift data changed on clock edge");
    blink_cap_a: assert property (mode == charge_led_pkg::MODE_SINGLE && !tst
        && s.blink_ms >= 10'h0384 |=> !o_led1_or_shift_clock_pin)
        else $error("single LED on beyond 90 percent of period");
    four_led_a: assert property (mode == charge_led_pkg::MODE_FOUR && !tst && s.disp_on
        && i_charge_percent > 7'h4B |=> o_led4_pin)
        else $error("fourth LED dark above three quarters");
endmodule

/* rtl/charge_led_pkg.sv */
// Purpose: Constants, register map and types for the charge, LED and alert logic.
// Assumes: 20 MHz core clock; all measurement inputs already digitised.
// Notes: Flag word layout matches the alert mask layout bit for bit.
package charge_led_pkg;
    // Timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SEC_LAST_MS = 10'h03E7;
    localparam logic [10:0] BTN_HOLD_MS = 11'h03E8;
    localparam logic [9:0] MS_PER_PCT = 10'h000A;
    localparam logic [6:0] BLINK_CAP_PCT = 7'h5A;
    localparam logic [6:0] PCT_FULL = 7'h64;
    // Charge termination and reporting.
    localparam logic [15:0] TAPER_DELTA_MIN = 16'h0019;
    localparam logic [1:0] TAPER_LAST_WIN = 2'h1;
    localparam logic [7:0] FULL_CHARGE_SET_PERCENT_DISABLED = 8'hFF;
    localparam logic [15:0] REPORT_MAX = 16'h7FFF;
    // Register indices.
    localparam logic [3:0] A_LED_CFG = 4'h0;
    localparam logic [3:0] A_ALERT_MASK = 4'h1;
    localparam logic [3:0] A_PACK_CFG = 4'h2;
    localparam logic [3:0] A_OT_QUAL = 4'h3;
    localparam logic [3:0] A_OT_THR = 4'h4;
    localparam logic [3:0] A_OT_REC = 4'h5;
    localparam logic [3:0] A_DSG_THR = 4'h6;
    localparam logic [3:0] A_TAPER_I = 4'h7;
    localparam logic [3:0] A_CHG_V = 4'h8;
    localparam logic [3:0] A_TAPER_V = 4'h9;
    localparam logic [3:0] A_FULL_CHARGE_SET_PERCENT = 4'hA;
    localparam logic [3:0] A_HOLD = 4'hB;
    localparam logic [3:0] A_LED_TEST = 4'hC;
    localparam logic [3:0] A_FLAGS = 4'hD;
    localparam logic [3:0] A_REM_CAP = 4'hE;
    localparam logic [3:0] A_FULL_CAP = 4'hF;
    // Field positions and reset values.
    localparam int LED_ON_BIT = 3;
    localparam int LED_CNT_LSB = 4;
    localparam int PACK_X10_BIT = 7;
    localparam int PACK_REMAINING_EQUALS_FULL_ENABLE_BIT = 4;
    localparam int TEST_EN_BIT = 4;
    localparam int FLG_OTD = 14;
    localparam int FLG_FC = 9;
    localparam int FLG_CHG = 8;
    localparam int FLG_OCV = 7;
    localparam logic [15:0] EXT_FLAG_MASK = 16'hB867;
    localparam logic [7:0] LED_CFG_RST = 8'h00;
    localparam logic [15:0] ALERT_MASK_RST = 16'h0000;
    localparam logic [7:0] PACK_CFG_RST = 8'h10;
    // Display modes.
    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_SINGLE = 3'b001,
        MODE_FOUR = 3'b010,
        MODE_EXT_TWO = 3'b011,
        MODE_EXT_ONE = 3'b100
    } disp_mode_t;
    // Shift-out states.
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_DATA = 2'b01,
        SH_CLK = 2'b10
    } sh_state_t;
endpackage
